// ==== sbt_dir_if.sv ====
// Purpose: Controls and results of one 9-bit transfer direction
// Assumes: Driven by the transceiver top
// Notes: Output enables are active low
`timescale 1ns/100ps
`default_nettype none
interface sbt_dir_if;
	logic le;
	logic store_clk;
	logic oe_n;
	logic test_mode;
	logic test_oe_n;
	logic [sbt_pkg::SBT_HALF_W-1:0] din;
	logic [sbt_pkg::SBT_HALF_W-1:0] test_dout;
	logic [sbt_pkg::SBT_HALF_W-1:0] dout;
	logic dout_oe_n;
	modport ctl(output le, store_clk, oe_n, test_mode, test_oe_n, din, test_dout, input dout, dout_oe_n);
	modport path(input le, store_clk, oe_n, test_mode, test_oe_n, din, test_dout, output dout, dout_oe_n);
endinterface // sbt_dir_if
`default_nettype wire

// ==== sbt_dir_path.sv ====
// Purpose: One direction of one half: latch, edge store and output drive
// Assumes: Store clock is a sampled level on core_clk_in
// Notes: Outputs lag the inputs by one core clock
`timescale 1ns/100ps
`default_nettype none
module sbt_dir_path
(
	input wire logic core_clk_in,
	input wire logic reset_in,
	sbt_dir_if.path dir
);
	logic clk_prev_reg;
	logic clk_prev_next;
	logic [sbt_pkg::SBT_HALF_W-1:0] store_reg;
	logic [sbt_pkg::SBT_HALF_W-1:0] store_next;
	logic [sbt_pkg::SBT_HALF_W-1:0] dout_reg;
	logic [sbt_pkg::SBT_HALF_W-1:0] dout_next;
	logic oe_n_reg;
	logic oe_n_next;
	logic rise;

	always_comb
	begin
		rise = dir.store_clk & ~clk_prev_reg;
		clk_prev_next = dir.store_clk;
		store_next = store_reg;
		// Storage frozen in test mode; normal value resumes at once after
		if (!dir.test_mode && (dir.le || rise))
			store_next = dir.din;
		if (dir.test_mode)
		begin
			dout_next = dir.test_dout;
			oe_n_next = dir.test_oe_n;
		end
		else
		begin
			dout_next = store_next;
			oe_n_next = dir.oe_n;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			// Follow the pin so a high store clock at release is no edge
			clk_prev_reg <= dir.store_clk;
			store_reg <= '0;
			dout_reg <= '0;
			oe_n_reg <= 1'b1;
		end
		else
		begin
			clk_prev_reg <= clk_prev_next;
			store_reg <= store_next;
			dout_reg <= dout_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign dir.dout = dout_reg;
	assign dir.dout_oe_n = oe_n_reg;

	property p_transparent;
		@(posedge core_clk_in) disable iff (reset_in)
		!dir.test_mode && dir.le |=> dir.dout == $past(dir.din);
	endproperty
	a_transparent: assert property (p_transparent) else $error("transparent path lost");

	property p_hold;
		@(posedge core_clk_in) disable iff (reset_in)
		(!dir.test_mode && !dir.le && !rise) [*2] |=> $stable(dir.dout);
	endproperty
	a_hold: assert property (p_hold) else $error("held data changed");

	property p_edge_store;
		@(posedge core_clk_in) disable iff (reset_in)
		!dir.test_mode && !dir.le && $rose(dir.store_clk) |=> dir.dout == $past(dir.din);
	endproperty
	a_edge_store: assert property (p_edge_store) else $error("edge store missed");

	property p_drive;
		@(posedge core_clk_in) disable iff (reset_in)
		!dir.test_mode && !dir.oe_n |=> !dir.dout_oe_n;
	endproperty
	a_drive: assert property (p_drive) else $error("output not driven");

	property p_float;
		@(posedge core_clk_in) disable iff (reset_in)
		!dir.test_mode && dir.oe_n |=> dir.dout_oe_n;
	endproperty
	a_float: assert property (p_float) else $error("output not released");

	property p_test_override;
		@(posedge core_clk_in) disable iff (reset_in)
		dir.test_mode |=> dir.dout == $past(dir.test_dout) && dir.dout_oe_n == $past(dir.test_oe_n);
	endproperty
	a_test_override: assert property (p_test_override) else $error("test drive ignored");

	c_edge_store: cover property (@(posedge core_clk_in) disable iff (reset_in)
		!dir.test_mode && !dir.le && rise);
endmodule // sbt_dir_path
`default_nettype wire

// ==== sbt_pkg.sv ====
// Purpose: Shared constants, types and helpers for the scan bus transceiver
// Assumes: All pins sampled on core_clk_in, test clock included
// Notes: Opcodes other than the reset opcode are arbitrary picks
`default_nettype none
package sbt_pkg;
	localparam int SBT_HALF_W = 9;
	localparam int SBT_HALVES = 2;
	localparam int SBT_BUS_W = 18;
	localparam int SBT_BSR_W = 48;
	localparam int SBT_DATA_W = 36;
	localparam int SBT_IR_W = 8;
	localparam int SBT_BCR_W = 3;
	localparam int SBT_ID_W = 32;
	localparam int SBT_BSR_OE_LSB = 44;
	localparam int SBT_BSR_A_LSB = 18;
	localparam int SBT_BSR_B_LSB = 0;
	localparam int SBT_LFSR_TAP = 11;
	localparam int SBT_TLR_TMS_CYCLES = 5;
	localparam logic [2:0] SBT_TMS_CNT_MAX = 3'h5;
	localparam logic [7:0] SBT_IR_RESET = 8'h81;
	localparam logic [7:0] SBT_OP_IDCODE = 8'h81;
	localparam logic [7:0] SBT_OP_EXTEST = 8'h00;
	localparam logic [7:0] SBT_OP_SAMPLE = 8'h82;
	localparam logic [7:0] SBT_OP_RUNT = 8'h09;
	localparam logic [7:0] SBT_OP_BCR = 8'h8E;
	localparam logic [2:0] SBT_BCR_RESET = 3'h2;
	localparam logic [2:0] SBT_BCR_PSA = 3'h2;
	localparam logic [2:0] SBT_BCR_OUTPUT_PSEUDO_RANDOM_GEN = 3'h1;
	localparam logic [3:0] SBT_OE_CELLS_RESET = 4'hF;
	// Arbitrary identification value
	localparam logic [31:0] SBT_IDCODE = 32'h0000_0001;

	typedef enum logic [3:0] {
		SBT_TLR, SBT_RTI, SBT_SEL_DR, SBT_CAP_DR, SBT_SH_DR, SBT_EX1_DR, SBT_PAU_DR, SBT_EX2_DR,
		SBT_UPD_DR, SBT_SEL_IR, SBT_CAP_IR, SBT_SH_IR, SBT_EX1_IR, SBT_PAU_IR, SBT_EX2_IR, SBT_UPD_IR
	} sbt_tap_e;

	function automatic sbt_tap_e sbt_tap_next(input sbt_tap_e s, input logic tms);
		sbt_tap_e n;
		unique case (s)
			SBT_TLR: n = tms ? SBT_TLR : SBT_RTI;
			SBT_RTI: n = tms ? SBT_SEL_DR : SBT_RTI;
			SBT_SEL_DR: n = tms ? SBT_SEL_IR : SBT_CAP_DR;
			SBT_CAP_DR: n = tms ? SBT_EX1_DR : SBT_SH_DR;
			SBT_SH_DR: n = tms ? SBT_EX1_DR : SBT_SH_DR;
			SBT_EX1_DR: n = tms ? SBT_UPD_DR : SBT_PAU_DR;
			SBT_PAU_DR: n = tms ? SBT_EX2_DR : SBT_PAU_DR;
			SBT_EX2_DR: n = tms ? SBT_UPD_DR : SBT_SH_DR;
			SBT_UPD_DR: n = tms ? SBT_SEL_DR : SBT_RTI;
			SBT_SEL_IR: n = tms ? SBT_TLR : SBT_CAP_IR;
			SBT_CAP_IR: n = tms ? SBT_EX1_IR : SBT_SH_IR;
			SBT_SH_IR: n = tms ? SBT_EX1_IR : SBT_SH_IR;
			SBT_EX1_IR: n = tms ? SBT_UPD_IR : SBT_PAU_IR;
			SBT_PAU_IR: n = tms ? SBT_EX2_IR : SBT_PAU_IR;
			SBT_EX2_IR: n = tms ? SBT_UPD_IR : SBT_SH_IR;
			SBT_UPD_IR: n = tms ? SBT_SEL_DR : SBT_RTI;
		endcase
		return n;
	endfunction

	// One step of the signature (shift cells) / pattern (update cells) shift register
	function automatic logic [35:0] sbt_lfsr(input logic [35:0] s, input logic [35:0] d);
		logic fb;
		fb = s[0] ^ s[SBT_LFSR_TAP];
		return {fb, s[35:1]} ^ d;
	endfunction

	function automatic logic sbt_is_bsr(input logic [7:0] op);
		return (op == SBT_OP_EXTEST) || (op == SBT_OP_SAMPLE) || (op == SBT_OP_RUNT);
	endfunction

	function automatic logic sbt_is_test(input logic [7:0] op);
		return (op == SBT_OP_EXTEST) || (op == SBT_OP_RUNT);
	endfunction
endpackage
`default_nettype wire

// ==== sbt_tester.sv ====
// Purpose: Far-side scan tester driving the four-wire test port
// Assumes: Test clock held low four core clocks and high three core clocks
// Notes: Test clock stands high between steps; TDI idles high as if pulled up
`timescale 1ns/100ps
`default_nettype none
module sbt_tester
(
	input wire logic clk_in,
	input wire logic tdo_in,
	input wire logic tdo_oe_n_in,
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out
);
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
	end

	// Inputs change on the fall, TDO is read just before the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
		@(posedge clk_in);
		tck_out <= 1'b0;
		tms_out <= tms;
		tdi_out <= tdi;
		repeat (3) @(posedge clk_in);
		#1;
		// Released TDO reads inverted so a missing enable shows
		tdo = tdo_oe_n_in ? ~tdo_in : tdo_in;
		oe_n = tdo_oe_n_in;
		@(posedge clk_in);
		tck_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask

	task automatic tap_reset();
		logic d;
		logic e;
		repeat (5) step(1'b1, 1'b1, d, e);
	endtask

	// From reset or idle: load op, return captured bits, end in idle
	task automatic ir_scan(input logic [7:0] op, output logic [7:0] cap, output logic oe_n);
		logic d;
		logic e;
		oe_n = 1'b0;
		step(1'b0, 1'b1, d, e);
		step(1'b1, 1'b1, d, e);
		step(1'b1, 1'b1, d, e);
		step(1'b0, 1'b1, d, e);
		step(1'b0, 1'b1, d, e);
		for (int i = 0; i < 8; i++)
		begin
			step(i == 7, op[i], d, e);
			cap[i] = d;
			oe_n = oe_n | e;
		end
		step(1'b1, 1'b1, d, e);
		step(1'b0, 1'b1, d, e);
	endtask

	// From idle: capture, shift 48 boundary bits, update, end in idle
	task automatic dr_scan(input logic [47:0] din, output logic [47:0] cap);
		logic d;
		logic e;
		cap = 48'h0;
		step(1'b1, 1'b1, d, e);
		step(1'b0, 1'b1, d, e);
		step(1'b0, 1'b1, d, e);
		for (int i = 0; i < 48; i++)
		begin
			step(i == 47, din[i], d, e);
			cap[i] = d;
		end
		step(1'b1, 1'b1, d, e);
		step(1'b0, 1'b1, d, e);
	endtask
endmodule // sbt_tester
`default_nettype wire

// ==== sbt_transceiver.sv ====
// Purpose: 18-bit two-way bus transceiver with boundary-scan test access
// Assumes: Test clock and all pins are synchronous levels on core_clk_in
// Notes: Test clock edges are found by sampling, so it must run well below 125 MHz
`timescale 1ns/100ps
`default_nettype none
module sbt_transceiver
(
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [sbt_pkg::SBT_BUS_W-1:0] a_in,
	input wire logic [sbt_pkg::SBT_BUS_W-1:0] b_in,
	input wire logic [sbt_pkg::SBT_HALVES-1:0] a_to_b_output_enable_n_in,
	input wire logic [sbt_pkg::SBT_HALVES-1:0] b_to_a_output_enable_n_in,
	input wire logic [sbt_pkg::SBT_HALVES-1:0] a_to_b_latch_enable_in,
	input wire logic [sbt_pkg::SBT_HALVES-1:0] b_to_a_latch_enable_in,
	input wire logic [sbt_pkg::SBT_HALVES-1:0] a_to_b_store_clock_in,
	input wire logic [sbt_pkg::SBT_HALVES-1:0] b_to_a_store_clock_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic [sbt_pkg::SBT_BUS_W-1:0] a_out,
	output logic [sbt_pkg::SBT_HALVES-1:0] a_oe_n_out,
	output logic [sbt_pkg::SBT_BUS_W-1:0] b_out,
	output logic [sbt_pkg::SBT_HALVES-1:0] b_oe_n_out,
	output logic tdo_out,
	output logic tdo_oe_n_out
);
	sbt_pkg::sbt_tap_e state_reg;
	sbt_pkg::sbt_tap_e state_next;
	logic tck_prev_reg;
	logic tck_prev_next;
	logic [sbt_pkg::SBT_IR_W-1:0] ir_reg;
	logic [sbt_pkg::SBT_IR_W-1:0] ir_next;
	logic [sbt_pkg::SBT_IR_W-1:0] ir_sh_reg;
	logic [sbt_pkg::SBT_IR_W-1:0] ir_sh_next;
	logic [sbt_pkg::SBT_BSR_W-1:0] dr_sh_reg;
	logic [sbt_pkg::SBT_BSR_W-1:0] dr_sh_next;
	logic [sbt_pkg::SBT_BSR_W-1:0] upd_reg;
	logic [sbt_pkg::SBT_BSR_W-1:0] upd_next;
	logic [sbt_pkg::SBT_BCR_W-1:0] bcr_reg;
	logic [sbt_pkg::SBT_BCR_W-1:0] bcr_next;
	logic tdo_reg;
	logic tdo_next;
	logic tdo_oe_n_reg;
	logic tdo_oe_n_next;
	logic test_mode_reg;
	logic test_mode_next;
	logic tck_rise;
	logic tck_fall;
	logic [sbt_pkg::SBT_BSR_W-1:0] pins;
	logic [2:0] tms_cnt_reg;
	logic [2:0] tms_cnt_next;

	// Boundary snapshot: enable cells on top, then controls, A, B
	assign pins = {b_to_a_output_enable_n_in[1], a_to_b_output_enable_n_in[1],
		b_to_a_output_enable_n_in[0], a_to_b_output_enable_n_in[0],
		b_to_a_store_clock_in, a_to_b_store_clock_in,
		b_to_a_latch_enable_in, a_to_b_latch_enable_in, a_in, b_in};

	always_comb
	begin
		tck_rise = tck_in & ~tck_prev_reg;
		tck_fall = ~tck_in & tck_prev_reg;
		tck_prev_next = tck_in;
		state_next = state_reg;
		ir_next = ir_reg;
		ir_sh_next = ir_sh_reg;
		dr_sh_next = dr_sh_reg;
		upd_next = upd_reg;
		bcr_next = bcr_reg;
		tdo_next = tdo_reg;
		tdo_oe_n_next = tdo_oe_n_reg;
		if (tck_rise)
		begin
			state_next = sbt_pkg::sbt_tap_next(state_reg, tms_in);
			if (state_reg == sbt_pkg::SBT_CAP_IR)
				ir_sh_next = sbt_pkg::SBT_IR_RESET;
			if (state_reg == sbt_pkg::SBT_SH_IR)
				ir_sh_next = {tdi_in, ir_sh_reg[sbt_pkg::SBT_IR_W-1:1]};
			if (state_reg == sbt_pkg::SBT_CAP_DR)
			begin
				dr_sh_next = '0;
				if (sbt_pkg::sbt_is_bsr(ir_reg))
					dr_sh_next = pins;
				else if (ir_reg == sbt_pkg::SBT_OP_IDCODE)
					dr_sh_next[sbt_pkg::SBT_ID_W-1:0] = sbt_pkg::SBT_IDCODE;
				else if (ir_reg == sbt_pkg::SBT_OP_BCR)
					dr_sh_next[sbt_pkg::SBT_BCR_W-1:0] = bcr_reg;
			end
			if (state_reg == sbt_pkg::SBT_SH_DR)
			begin
				if (sbt_pkg::sbt_is_bsr(ir_reg))
					dr_sh_next = {tdi_in, dr_sh_reg[sbt_pkg::SBT_BSR_W-1:1]};
				else if (ir_reg == sbt_pkg::SBT_OP_IDCODE)
					dr_sh_next[sbt_pkg::SBT_ID_W-1:0] = {tdi_in, dr_sh_reg[sbt_pkg::SBT_ID_W-1:1]};
				else if (ir_reg == sbt_pkg::SBT_OP_BCR)
					dr_sh_next[sbt_pkg::SBT_BCR_W-1:0] = {tdi_in, dr_sh_reg[sbt_pkg::SBT_BCR_W-1:1]};
				else
					dr_sh_next[0] = tdi_in;
			end
			// Signature compression of the sampled data pins
			if (state_reg == sbt_pkg::SBT_RTI && ir_reg == sbt_pkg::SBT_OP_RUNT
				&& bcr_reg == sbt_pkg::SBT_BCR_PSA)
				dr_sh_next[sbt_pkg::SBT_DATA_W-1:0] = sbt_pkg::sbt_lfsr(
					dr_sh_reg[sbt_pkg::SBT_DATA_W-1:0], pins[sbt_pkg::SBT_DATA_W-1:0]);
		end
		if (tck_fall)
		begin
			// Test outputs only move on the falling edge
			tdo_oe_n_next = !(state_reg == sbt_pkg::SBT_SH_DR || state_reg == sbt_pkg::SBT_SH_IR);
			tdo_next = (state_reg == sbt_pkg::SBT_SH_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
			if (state_reg == sbt_pkg::SBT_UPD_IR)
				ir_next = ir_sh_reg;
			if (state_reg == sbt_pkg::SBT_UPD_DR && sbt_pkg::sbt_is_bsr(ir_reg))
				upd_next = dr_sh_reg;
			if (state_reg == sbt_pkg::SBT_UPD_DR && ir_reg == sbt_pkg::SBT_OP_BCR)
				bcr_next = dr_sh_reg[sbt_pkg::SBT_BCR_W-1:0];
			if (state_reg == sbt_pkg::SBT_RTI && ir_reg == sbt_pkg::SBT_OP_RUNT
				&& bcr_reg == sbt_pkg::SBT_BCR_OUTPUT_PSEUDO_RANDOM_GEN)
				upd_next[sbt_pkg::SBT_DATA_W-1:0] = sbt_pkg::sbt_lfsr(
					upd_reg[sbt_pkg::SBT_DATA_W-1:0], '0);
		end
		// Test-logic reset drops test mode and makes the enable cells benign
		if (state_reg == sbt_pkg::SBT_TLR)
		begin
			ir_next = sbt_pkg::SBT_IR_RESET;
			bcr_next = sbt_pkg::SBT_BCR_RESET;
			upd_next[sbt_pkg::SBT_BSR_W-1:sbt_pkg::SBT_BSR_OE_LSB] = sbt_pkg::SBT_OE_CELLS_RESET;
			dr_sh_next[sbt_pkg::SBT_BSR_W-1:sbt_pkg::SBT_BSR_OE_LSB] = sbt_pkg::SBT_OE_CELLS_RESET;
		end
		test_mode_next = sbt_pkg::sbt_is_test(ir_next);
	end

	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			state_reg <= sbt_pkg::SBT_TLR;
			// Follow the pin so a test clock idling high gives no false rise
			tck_prev_reg <= tck_in;
			ir_reg <= sbt_pkg::SBT_IR_RESET;
			ir_sh_reg <= sbt_pkg::SBT_IR_RESET;
			dr_sh_reg <= '0;
			upd_reg <= {sbt_pkg::SBT_OE_CELLS_RESET, {(sbt_pkg::SBT_BSR_OE_LSB){1'b0}}};
			bcr_reg <= sbt_pkg::SBT_BCR_RESET;
			tdo_reg <= 1'b0;
			tdo_oe_n_reg <= 1'b1;
			test_mode_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			tck_prev_reg <= tck_prev_next;
			ir_reg <= ir_next;
			ir_sh_reg <= ir_sh_next;
			dr_sh_reg <= dr_sh_next;
			upd_reg <= upd_next;
			bcr_reg <= bcr_next;
			tdo_reg <= tdo_next;
			tdo_oe_n_reg <= tdo_oe_n_next;
			test_mode_reg <= test_mode_next;
		end
	end

	assign tdo_out = tdo_reg;
	assign tdo_oe_n_out = tdo_oe_n_reg;

	// Four independent paths: two halves, two directions
	for (genvar h = 0; h < sbt_pkg::SBT_HALVES; h++)
	begin : g_half
		sbt_dir_if ab_if();
		sbt_dir_if ba_if();

		assign ab_if.le = a_to_b_latch_enable_in[h];
		assign ab_if.store_clk = a_to_b_store_clock_in[h];
		assign ab_if.oe_n = a_to_b_output_enable_n_in[h];
		assign ab_if.din = a_in[h*sbt_pkg::SBT_HALF_W +: sbt_pkg::SBT_HALF_W];
		assign ab_if.test_mode = test_mode_reg;
		assign ab_if.test_dout = upd_reg[sbt_pkg::SBT_BSR_B_LSB + h*sbt_pkg::SBT_HALF_W +: sbt_pkg::SBT_HALF_W];
		assign ab_if.test_oe_n = upd_reg[sbt_pkg::SBT_BSR_OE_LSB + 2*h];
		assign b_out[h*sbt_pkg::SBT_HALF_W +: sbt_pkg::SBT_HALF_W] = ab_if.dout;
		assign b_oe_n_out[h] = ab_if.dout_oe_n;

		// Mirror direction with its own controls
		assign ba_if.le = b_to_a_latch_enable_in[h];
		assign ba_if.store_clk = b_to_a_store_clock_in[h];
		assign ba_if.oe_n = b_to_a_output_enable_n_in[h];
		assign ba_if.din = b_in[h*sbt_pkg::SBT_HALF_W +: sbt_pkg::SBT_HALF_W];
		assign ba_if.test_mode = test_mode_reg;
		assign ba_if.test_dout = upd_reg[sbt_pkg::SBT_BSR_A_LSB + h*sbt_pkg::SBT_HALF_W +: sbt_pkg::SBT_HALF_W];
		assign ba_if.test_oe_n = upd_reg[sbt_pkg::SBT_BSR_OE_LSB + 2*h + 1];
		assign a_out[h*sbt_pkg::SBT_HALF_W +: sbt_pkg::SBT_HALF_W] = ba_if.dout;
		assign a_oe_n_out[h] = ba_if.dout_oe_n;

		sbt_dir_path u_ab
		(
			.core_clk_in(core_clk_in),
			.reset_in(reset_in),
			.dir(ab_if.path)
		);

		sbt_dir_path u_ba
		(
			.core_clk_in(core_clk_in),
			.reset_in(reset_in),
			.dir(ba_if.path)
		);
	end

	// Checking aid: test clock rises seen with TMS high in a row
	always_comb
	begin
		tms_cnt_next = tms_cnt_reg;
		if (tck_rise && !tms_in)
			tms_cnt_next = 3'h0;
		else if (tck_rise && tms_cnt_reg != sbt_pkg::SBT_TMS_CNT_MAX)
			tms_cnt_next = tms_cnt_reg + 3'h1;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			tms_cnt_reg <= 3'h0;
		else
			tms_cnt_reg <= tms_cnt_next;
	end

	property p_tlr_reach;
		@(posedge core_clk_in) disable iff (reset_in)
		tms_cnt_reg == sbt_pkg::SBT_TMS_CNT_MAX |-> state_reg == sbt_pkg::SBT_TLR;
	endproperty
	a_tlr_reach: assert property (p_tlr_reach) else $error("no test reset after five TMS highs");

	property p_oe_cells;
		@(posedge core_clk_in) disable iff (reset_in)
		state_reg == sbt_pkg::SBT_TLR |=>
			upd_reg[sbt_pkg::SBT_BSR_W-1:sbt_pkg::SBT_BSR_OE_LSB] == sbt_pkg::SBT_OE_CELLS_RESET && !test_mode_reg;
	endproperty
	a_oe_cells: assert property (p_oe_cells) else $error("enable cells not reset");

	property p_tdo_on_fall;
		@(posedge core_clk_in) disable iff (reset_in)
		$changed(tdo_out) || $changed(tdo_oe_n_out) |-> $past(tck_fall);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("TDO moved off a falling edge");

	property p_ir_shift;
		@(posedge core_clk_in) disable iff (reset_in)
		tck_rise && state_reg == sbt_pkg::SBT_SH_IR |=> ir_sh_reg[sbt_pkg::SBT_IR_W-1] == $past(tdi_in);
	endproperty
	a_ir_shift: assert property (p_ir_shift) else $error("TDI not shifted in");

	property p_normal_flow;
		@(posedge core_clk_in) disable iff (reset_in)
		!test_mode_reg && a_to_b_latch_enable_in[0] |=>
			b_out[sbt_pkg::SBT_HALF_W-1:0] == $past(a_in[sbt_pkg::SBT_HALF_W-1:0]);
	endproperty
	a_normal_flow: assert property (p_normal_flow) else $error("normal flow disturbed");

	property p_resume;
		@(posedge core_clk_in) disable iff (reset_in)
		$fell(test_mode_reg) && b_to_a_latch_enable_in[1] |=>
			a_out[sbt_pkg::SBT_BUS_W-1:sbt_pkg::SBT_HALF_W] == $past(b_in[sbt_pkg::SBT_BUS_W-1:sbt_pkg::SBT_HALF_W]);
	endproperty
	a_resume: assert property (p_resume) else $error("no transparent resume");

	property p_ir_capture;
		@(posedge core_clk_in) disable iff (reset_in)
		tck_rise && state_reg == sbt_pkg::SBT_CAP_IR |=> ir_sh_reg == sbt_pkg::SBT_IR_RESET;
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("status value not captured");

	property p_tdo_enable;
		@(posedge core_clk_in) disable iff (reset_in)
		tck_fall && (state_reg == sbt_pkg::SBT_SH_IR || state_reg == sbt_pkg::SBT_SH_DR) |=> !tdo_oe_n_out;
	endproperty
	a_tdo_enable: assert property (p_tdo_enable) else $error("TDO not enabled while shifting");

	property p_sample_capture;
		@(posedge core_clk_in) disable iff (reset_in)
		tck_rise && state_reg == sbt_pkg::SBT_CAP_DR && sbt_pkg::sbt_is_bsr(ir_reg) |=> dr_sh_reg == $past(pins);
	endproperty
	a_sample_capture: assert property (p_sample_capture) else $error("pin snapshot missed");

	property p_update_dr;
		@(posedge core_clk_in) disable iff (reset_in)
		tck_fall && state_reg == sbt_pkg::SBT_UPD_DR && sbt_pkg::sbt_is_bsr(ir_reg) |=> upd_reg == $past(dr_sh_reg);
	endproperty
	a_update_dr: assert property (p_update_dr) else $error("boundary cells not updated");

	c_shift_dr: cover property (@(posedge core_clk_in) disable iff (reset_in)
		tck_rise && state_reg == sbt_pkg::SBT_SH_DR);
	c_test_mode: cover property (@(posedge core_clk_in) disable iff (reset_in) $rose(test_mode_reg));
	c_psa: cover property (@(posedge core_clk_in) disable iff (reset_in)
		tck_rise && state_reg == sbt_pkg::SBT_RTI && ir_reg == sbt_pkg::SBT_OP_RUNT);
endmodule // sbt_transceiver
`default_nettype wire

// ==== sbt_transceiver_bench.sv ====
// Purpose: Self-checking bench for the scan bus transceiver
// Assumes: Outputs show the inputs of one edge at the next edge
// Notes: Data is not compared where an output is expected released
`timescale 1ns/100ps
`default_nettype none
module sbt_transceiver_bench;
	typedef struct {int due; logic [35:0] val; logic [3:0] oe;} sbt_note_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [17:0] a_in = 18'h0;
	logic [17:0] b_in = 18'h0;
	logic [1:0] oe_ab = 2'h0;
	logic [1:0] oe_ba = 2'h0;
	logic [1:0] le_ab = 2'h3;
	logic [1:0] le_ba = 2'h3;
	logic [1:0] ck_ab = 2'h0;
	logic [1:0] ck_ba = 2'h0;
	wire logic tck, tms, tdi, tdo, tdo_oe_n;
	wire logic [17:0] a_out, b_out;
	wire logic [1:0] a_oe_n, b_oe_n;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	sbt_note_s q[$];
	logic [17:0] st_ab = 18'h0;
	logic [17:0] st_ba = 18'h0;
	logic [1:0] p_ab = 2'h0;
	logic [1:0] p_ba = 2'h0;
	logic [47:0] preload = 48'h0;

	sbt_transceiver dut_u (.core_clk_in(clk), .reset_in(rst), .a_in(a_in), .b_in(b_in),
		.a_to_b_output_enable_n_in(oe_ab), .b_to_a_output_enable_n_in(oe_ba),
		.a_to_b_latch_enable_in(le_ab), .b_to_a_latch_enable_in(le_ba),
		.a_to_b_store_clock_in(ck_ab), .b_to_a_store_clock_in(ck_ba),
		.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .a_out(a_out), .a_oe_n_out(a_oe_n),
		.b_out(b_out), .b_oe_n_out(b_oe_n), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n));
	sbt_tester tst_u (.clk_in(clk), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n), .tck_out(tck), .tms_out(tms),
		.tdi_out(tdi));

	initial
	begin
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [35:0] got, input logic [35:0] exp, input string msg);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Random traffic on all four paths; test mode holds controls still
	task automatic traffic(input int n, input bit test);
		sbt_note_s nt;
		logic [1:0] lab, lba, cab, cba;
		logic [17:0] da, db;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			da = 18'($urandom);
			db = 18'($urandom);
			lab = (test || i == 0) ? 2'h3 : 2'($urandom);
			lba = (test || i == 0) ? 2'h3 : 2'($urandom);
			cab = test ? 2'h0 : 2'($urandom);
			cba = test ? 2'h0 : 2'($urandom);
			a_in <= da;
			b_in <= db;
			le_ab <= lab;
			le_ba <= lba;
			ck_ab <= cab;
			ck_ba <= cba;
			oe_ab <= test ? 2'h0 : 2'($urandom);
			oe_ba <= test ? 2'h0 : 2'($urandom);
			#1;
			for (int h = 0; h < 2; h++)
			begin
				if (!test && (lab[h] || (cab[h] && !p_ab[h])))
					st_ab[h*9+:9] = da[h*9+:9];
				if (!test && (lba[h] || (cba[h] && !p_ba[h])))
					st_ba[h*9+:9] = db[h*9+:9];
			end
			p_ab = cab;
			p_ba = cba;
			nt.due = cyc + 1;
			// Test mode shows the preloaded boundary cells
			nt.val = test ? preload[35:0] : {st_ba, st_ab};
			nt.oe = test ? {preload[47], preload[45], preload[46], preload[44]} : {oe_ba, oe_ab};
			q.push_back(nt);
		end
	endtask

	// Watcher: one note per cycle, released halves masked
	initial
	begin
		sbt_note_s nt;
		logic [35:0] m;
		forever
		begin
			@(posedge clk);
			#1;
			while (q.size() > 0 && q[0].due == cyc)
			begin
				nt = q.pop_front();
				m = {{9{~nt.oe[3]}}, {9{~nt.oe[2]}}, {9{~nt.oe[1]}}, {9{~nt.oe[0]}}};
				check({32'h0, a_oe_n, b_oe_n}, {32'h0, nt.oe}, "enables");
				check({a_out, b_out} & m, nt.val & m, "data");
			end
		end
	end

	// Cycle count on the falling edge so drivers and watcher agree
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			mismatches++;
			complete_run();
		end
	end

	initial
	begin
		logic [7:0] cap;
		logic en_n;
		logic [47:0] scan_cap;
		logic [11:0] ctl_pins;
		void'($urandom(44926));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		traffic(300, 1'b0);
		$display("test datapath done");
		fork
			traffic(400, 1'b0);
			tst_u.ir_scan(sbt_pkg::SBT_OP_SAMPLE, cap, en_n);
		join
		check({28'h0, cap}, {28'h0, sbt_pkg::SBT_IR_RESET}, "captured instruction");
		check({35'h0, en_n}, 36'h0, "scan output enable");
		$display("test scan in normal mode done");
		preload = {16'($urandom), 32'($urandom)};
		// Keep one half driven so test data is always compared
		preload[44] = 1'b0;
		tst_u.dr_scan(preload, scan_cap);
		ctl_pins = {oe_ba[1], oe_ab[1], oe_ba[0], oe_ab[0], ck_ba, ck_ab, le_ba, le_ab};
		check(scan_cap[35:0], {a_in, b_in}, "sampled data pins");
		check({24'h0, scan_cap[47:36]}, {24'h0, ctl_pins}, "sampled control pins");
		$display("test boundary sample done");
		tst_u.ir_scan(sbt_pkg::SBT_OP_EXTEST, cap, en_n);
		check({28'h0, cap}, {28'h0, sbt_pkg::SBT_IR_RESET}, "second captured instruction");
		traffic(40, 1'b1);
		$display("test boundary mode done");
		tst_u.tap_reset();
		traffic(100, 1'b0);
		$display("test scan reset done");
		repeat (3) @(posedge clk);
		complete_run();
	end
endmodule // sbt_transceiver_bench
`default_nettype wire
